// ---- rtl/sps_ctrl.sv ----
// Controller end: strap check, firmware load, sleep request and state recovery
// Contract
// - Tandem mode only when supervisor strap present
// - Load supervisor firmware on very first power-up
// - Standby with supervisor: periodically request sleep
// - Supervisor removes controller supply on sleep
// - Supply removal is a full reset
// - Supervisor retains charge, mode, fault state
// - Supervisor drives LEDs during controller off
// - Supervisor times the off period
// - Ping every 400 ms, never longer; tandem pings only on restore: none out of standby, 4+ cycles late in standby
module sps_ctrl (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   sps_link_if.ctrl link,
   input wire logic first_boot_in,
   input wire logic standby_in,
   input wire sps_pkg::sps_state_t state_in,
   input wire logic state_we_in,
   output logic ping_out,
   output logic ready_out,
   output logic tandem_out,
   output sps_pkg::sps_state_t state_out,
   output logic [sps_pkg::LED_W-1:0] led_out
);
   import sps_pkg::*;

   typedef enum logic [2:0] {ST_STRAP, ST_FW, ST_RESTORE, ST_RUN, ST_SLEEP} sps_cst_t;

   typedef struct packed {
      sps_cst_t st;
      logic tandem;
      logic [FW_AW-1:0] addr;
      logic fw_valid;
      logic fw_done;
      logic [CNT_W-1:0] cnt;
      logic sleep;
      logic ping;
      sps_state_t state;
   } sps_creg_t;

   sps_creg_t q, d;

   // Firmware image held inside the controller
   function automatic sps_fw_word_t fw_rom(input logic [FW_AW-1:0] a);
      return sps_fw_word_t'({a, ~a});
   endfunction

   always_comb begin
      d = q;
      d.ping = 1'b0;
      d.fw_done = 1'b0;
      unique case (q.st)
         ST_STRAP: begin
            d.tandem = link.present;
            if (!link.present) begin
               d.st = ST_RUN;
            end else if (first_boot_in) begin
               d.st = ST_FW;
               d.fw_valid = 1'b1;
               d.addr = FW_ZERO;
            end else begin
               d.st = ST_RESTORE;
            end
         end
         ST_FW: begin
            if (q.addr == FW_LAST) begin
               d.fw_valid = 1'b0;
               d.fw_done = 1'b1;
               d.st = ST_RESTORE;
            end else begin
               d.addr = q.addr + 1'b1;
            end
         end
         ST_RESTORE: begin
            if (link.restore_valid) begin
               d.state = link.restore_state;
               d.st = ST_RUN;
               d.ping = 1'b1;
               d.cnt = CNT_ZERO;
            end
         end
         ST_RUN: begin
            if (state_we_in) begin
               d.state = state_in;
            end
            if (q.tandem && standby_in) begin
               if (q.cnt >= CNT_W'(AWAKE_CYC - 1)) begin
                  d.st = ST_SLEEP;
                  d.sleep = 1'b1;
               end else begin
                  d.cnt = q.cnt + CNT_ONE;
               end
            end else if (q.tandem) begin
               // Awake window is timed from standby entry
               d.cnt = CNT_ZERO;
            end else if (q.cnt >= CNT_W'(PING_CYC - 1)) begin
               d.cnt = CNT_ZERO;
               d.ping = 1'b1;
            end else begin
               d.cnt = q.cnt + CNT_ONE;
            end
         end
         ST_SLEEP: begin
            d.sleep = 1'b1;
         end
         default: begin
            d.st = ST_STRAP;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         q <= '{st: ST_STRAP, tandem: 1'b0, addr: FW_ZERO, fw_valid: 1'b0, fw_done: 1'b0,
                cnt: CNT_ZERO, sleep: 1'b0, ping: 1'b0, state: STATE_RST};
      end else begin
         q <= d;
      end
   end

   assign link.fw_valid = q.fw_valid;
   assign link.fw_addr = q.addr;
   assign link.fw_data = fw_rom(q.addr);
   assign link.fw_done = q.fw_done;
   assign link.sleep_req = q.sleep;
   assign link.save_state = q.state;
   assign link.save_valid = q.tandem && (q.st == ST_RUN);
   assign ping_out = q.ping;
   assign ready_out = (q.st == ST_RUN);
   assign tandem_out = q.tandem;
   assign state_out = q.state;
   // LEDs are only driven locally when no supervisor is fitted
   assign led_out = q.tandem ? '0 : {q.state.fault, q.state.charge != '0};
endmodule

// ---- rtl/sps_link_if.sv ----
// Link between the controller and its supervisor
interface sps_link_if;
   import sps_pkg::*;
   logic present;
   logic fw_valid;
   logic [FW_AW-1:0] fw_addr;
   sps_fw_word_t fw_data;
   logic fw_done;
   logic sleep_req;
   sps_state_t save_state;
   logic save_valid;
   sps_state_t restore_state;
   logic restore_valid;
   logic ctrl_rst_n;
   logic ctrl_supply_en;

   modport ctrl (
      input present, restore_state, restore_valid,
      output fw_valid, fw_addr, fw_data, fw_done, sleep_req, save_state, save_valid
   );
   modport sup (
      output present, restore_state, restore_valid, ctrl_rst_n, ctrl_supply_en,
      input fw_valid, fw_addr, fw_data, fw_done, sleep_req, save_state, save_valid
   );
endinterface

// ---- rtl/sps_pkg.sv ----
// Shared constants and types for the standby supervisor handoff link
package sps_pkg;
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned PING_MS = 400;
   localparam int unsigned PING_CYC = PING_MS * 1000 * CLK_MHZ;
   localparam int unsigned FW_WORDS = 16;
   localparam int unsigned FW_AW = 4;
   localparam int unsigned AWAKE_CYC = 1000;
   localparam int unsigned CHG_W = 2;
   localparam int unsigned MODE_W = 2;
   localparam int unsigned LED_W = 2;
   localparam int unsigned CNT_W = 32;
   localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
   localparam logic [FW_AW-1:0] FW_LAST = 4'hF;
   localparam logic [FW_AW-1:0] FW_ZERO = 4'h0;

   typedef struct packed {
      logic [CHG_W-1:0] charge;
      logic fault;
      logic [MODE_W-1:0] mode;
   } sps_state_t;

   localparam sps_state_t STATE_RST = '{charge: 2'h0, fault: 1'b0, mode: 2'h0};

   typedef logic [7:0] sps_fw_word_t;
endpackage

// ---- rtl/sps_sup.sv ----
// Supervisor end: supply switch, off-period timing, state keeping and LEDs
module sps_sup (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   sps_link_if.sup link,
   input wire logic fitted_in,
   output logic fw_loaded_out,
   output logic [sps_pkg::LED_W-1:0] led_out
);
   import sps_pkg::*;

   typedef enum logic [1:0] {SU_ON, SU_OFF, SU_WAKE} sps_sst_t;

   typedef struct packed {
      sps_sst_t st;
      logic loaded;
      logic [FW_AW-1:0] words;
      logic [CNT_W-1:0] cnt;
      sps_state_t keep;
      logic restore;
      logic [LED_W-1:0] led;
   } sps_sreg_t;

   sps_sreg_t q, d;

   always_comb begin
      d = q;
      d.restore = 1'b0;
      if (link.fw_valid) begin
         d.words = link.fw_addr;
      end
      if (link.fw_done && q.words == FW_LAST) begin
         d.loaded = 1'b1;
      end
      if (link.save_valid) begin
         d.keep = link.save_state;
      end
      d.led = {d.keep.fault, d.keep.charge != '0};
      unique case (q.st)
         SU_ON: begin
            if (link.sleep_req) begin
               d.st = SU_OFF;
            end
         end
         SU_OFF: begin
            if (q.cnt >= CNT_W'(PING_CYC - AWAKE_CYC - 1)) begin
               d.st = SU_WAKE;
            end
         end
         SU_WAKE: begin
            d.restore = 1'b1;
            d.st = SU_ON;
         end
      endcase
      d.cnt = (q.st == SU_ON) ? CNT_ZERO : q.cnt + CNT_ONE;
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         q <= '{st: SU_ON, loaded: 1'b0, words: FW_ZERO, cnt: CNT_ZERO, keep: STATE_RST,
                restore: 1'b0, led: '0};
      end else begin
         q <= d;
      end
   end

   assign link.present = fitted_in;
   assign link.ctrl_supply_en = (q.st == SU_ON) || !fitted_in;
   assign link.ctrl_rst_n = (q.st == SU_ON);
   // Restore is offered whenever the supply is on and firmware has been loaded
   assign link.restore_valid = (q.st == SU_ON) && q.loaded;
   assign link.restore_state = q.keep;
   assign fw_loaded_out = q.loaded;
   assign led_out = q.led;
endmodule

// ---- test/sps_checker.sv ----
// Link checker for the controller and supervisor handoff
module sps_checker (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic present,
   input wire logic fw_valid,
   input wire logic [3:0] fw_addr,
   input wire logic fw_done,
   input wire logic sleep_req,
   input wire logic save_valid,
   input wire logic restore_valid,
   input wire logic ctrl_rst_n,
   input wire logic ctrl_supply_en
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   a_fw_addr_step: assert property (
      fw_valid && fw_addr != 4'hF |=> fw_valid && fw_addr == $past(fw_addr) + 4'h1)
      else $error("firmware address skipped");
   a_fw_done_last: assert property (fw_valid && fw_addr == 4'hF |=> fw_done)
      else $error("no done after last word");
   a_no_strap_load: assert property (!present |-> !fw_valid)
      else $error("load without supervisor");
   a_no_strap_sleep: assert property (!present |-> !sleep_req)
      else $error("sleep without supervisor");
   a_sleep_cuts_supply: assert property ($rose(sleep_req) |-> ##[1:2] !ctrl_supply_en)
      else $error("supply kept after sleep");
   a_sleep_holds: assert property (sleep_req && ctrl_rst_n |=> sleep_req)
      else $error("sleep request dropped");
   a_off_is_reset: assert property (!ctrl_supply_en |-> !ctrl_rst_n)
      else $error("controller out of reset while off");
   a_restore_when_on: assert property (restore_valid |-> ctrl_supply_en && present)
      else $error("restore while off");
   a_save_in_tandem: assert property (save_valid |-> present)
      else $error("save without supervisor");
endmodule

// ---- test/sps_test.sv ----
// Bench for the controller and supervisor handoff pair
module sps_test;
   timeunit 1ns;
   timeprecision 1ps;
   import sps_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, fitted = 1'b1, boot = 1'b1, stby = 1'b0, we = 1'b0;
   logic ping, rdy, tand, loaded;
   sps_state_t st = STATE_RST;
   sps_state_t st_q;
   logic [LED_W-1:0] led_c, led_s;
   int num_errors = 0, checks_done = 0, seed = 32'hb17d, n, pings = 0;
   sps_link_if link ();
   always #2 clk = ~clk;
   always @(posedge clk) if (ping) pings++;
   sps_ctrl sps_ctrl_inst (.sys_clk_in(clk), .rst_n_in(rst_n & link.ctrl_rst_n), .link(link.ctrl),
      .first_boot_in(boot), .standby_in(stby), .state_in(st), .state_we_in(we),
      .ping_out(ping), .ready_out(rdy), .tandem_out(tand), .state_out(st_q), .led_out(led_c));
   sps_sup sps_sup_inst (.sys_clk_in(clk), .rst_n_in(rst_n), .link(link.sup),
      .fitted_in(fitted), .fw_loaded_out(loaded), .led_out(led_s));
   sps_checker sps_checker_inst (.sys_clk_in(clk), .rst_n_in(rst_n), .present(link.present),
      .fw_valid(link.fw_valid), .fw_addr(link.fw_addr), .fw_done(link.fw_done),
      .sleep_req(link.sleep_req), .save_valid(link.save_valid),
      .restore_valid(link.restore_valid), .ctrl_rst_n(link.ctrl_rst_n),
      .ctrl_supply_en(link.ctrl_supply_en));
   task cmp(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task test_done;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   function logic [LED_W-1:0] led_of(input sps_state_t s);
      return {s.fault, s.charge != 2'h0};
   endfunction
   // Write one state, corner value first, then random ones
   task put_state(input int k);
      @(posedge clk);
      st <= sps_state_t'(k == 0 ? 32'h4 : $random(seed));
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
      @(negedge clk);
   endtask
   initial begin
      #200000;
      num_errors++;
      test_done;
   end
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      for (n = 0; n < 100 && link.fw_valid !== 1'b1; n++) @(negedge clk);
      for (int i = 0; i < FW_WORDS; i++) begin
         cmp({link.fw_valid, 3'h0, link.fw_addr}, {4'h8, i[3:0]});
         cmp(link.fw_data, {i[3:0], ~i[3:0]});
         @(negedge clk);
      end
      for (n = 0; n < 100 && rdy !== 1'b1; n++) @(negedge clk);
      cmp(loaded, 1'b1);
      cmp(tand, 1'b1);
      cmp(led_c, 8'h0);
      for (int k = 0; k < 5; k++) begin
         put_state(k);
         cmp(st_q, st);
         for (n = 0; n < 10 && led_s !== led_of(st); n++) @(negedge clk);
         cmp(led_s, led_of(st));
      end
      @(posedge clk);
      stby <= 1'b1;
      for (n = 0; n < 2 * AWAKE_CYC && link.sleep_req !== 1'b1; n++) @(negedge clk);
      cmp(n >= AWAKE_CYC - 4 && n <= AWAKE_CYC + 4, 1'b1);
      repeat (4) @(negedge clk);
      cmp(link.ctrl_supply_en, 1'b0);
      cmp({rdy, st_q}, 8'h0);
      cmp(led_s, led_of(st));
      cmp(pings != 0, 1'b1);
      @(posedge clk);
      rst_n <= 1'b0;
      fitted <= 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      put_state(0);
      n = 0;
      repeat (1500) begin
         @(negedge clk);
         if (link.sleep_req !== 1'b0) n++;
      end
      cmp(n, 8'h0);
      cmp(tand, 1'b0);
      cmp(led_c, led_of(st));
      test_done;
   end
endmodule
